// file: rtl/rio_pkg.sv
package rio_pkg;

    // ----------------------------------------------------------------
    // register byte addresses
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_IDX_FLAGS = 4'h0;   // event_flags index
    localparam logic [3:0] REG_IDX_ICTL  = 4'h6;   // interrupt_control index
    localparam logic [3:0] REG_IDX_STAT  = 4'h8;   // status/strobe index
    localparam logic [5:0] ADDR_FLAGS    = {REG_IDX_FLAGS, 2'b00};
    localparam logic [5:0] ADDR_ICTL     = {REG_IDX_ICTL, 2'b00};
    localparam logic [5:0] ADDR_STAT     = {REG_IDX_STAT, 2'b00};

    // ----------------------------------------------------------------
    // event_flags bit positions
    // ----------------------------------------------------------------
    localparam int FL_WDF  = 7;   // watchdog_timeout_flag
    localparam int FL_AF   = 6;   // alarm_match_flag
    localparam int FL_PF   = 5;   // power_fail_flag
    localparam int FL_OSC_STOP_FLAG = 4;   // osc_stop_flag
    localparam int FL_BPF  = 3;   // backup_fail_flag
    localparam int FL_CAL  = 2;   // calibration tone enable
    localparam int FL_W    = 1;   // write enable of flags
    localparam int FL_R    = 0;   // read latch (kept plain)

    // ----------------------------------------------------------------
    // interrupt_control bit positions and reset value
    // ----------------------------------------------------------------
    localparam int IC_WIE  = 7;
    localparam int IC_AIE  = 6;
    localparam int IC_PFE  = 5;
    localparam int IC_SQUARE_WAVE_ENABLE = 4;
    localparam int IC_HL   = 3;
    localparam int IC_PL   = 2;
    localparam int IC_SQ1  = 1;
    localparam int IC_SQ0  = 0;
    localparam logic [7:0] ICTL_RESET = 8'h08;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int  CLK_HZ        = 125_000_000;
    localparam int  OSC_HZ        = 32_768;
    localparam int  PULSE_MS      = 200;
    localparam int  PULSE_TICKS   = (2 * OSC_HZ * PULSE_MS) / 1000; // half periods
    localparam int  OSC_DIV       = CLK_HZ / (2 * OSC_HZ);         // half period

    // ----------------------------------------------------------------
    // axi responses
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic wdt;       // watchdog timeout
        logic alarm;     // alarm match
        logic pfail;     // power fail
        logic bakfail;   // backup below backup_fail_threshold
        logic oscstop;   // oscillator stopped
    } rio_events_t;

    typedef enum logic [1:0] {
        PIN_IDLE,
        PIN_LEVEL,
        PIN_PULSE
    } rio_pin_state_t;

endpackage

// file: rtl/rio_core.sv
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
// Behaviour
// - backup failure sets flag, seen at power-up
// - three sources, each with own enable
// - each source has own flag bit
// - interrupt needs flag and enable together
// - pulse mode drives pin about 200 ms
// - level mode holds pin until flags read
// - no interrupts while on backup supply
// - watchdog enable gates pin, flag always set
// - alarm enable gates pin, flag always set
// - power-fail enable gates pin, flag always
// - square wave replaces interrupt, calibration wins
// - square enable and select kept nonvolatile
// - select decodes 1, 512, 4096, 32768 Hz
// - polarity bit: high push-pull or low drain
// - flags read clears watchdog, alarm, power-fail and backup-fail flag bits
// - flags read ends pulse early
// - pin priority calibration, square, interrupt, hi-z
// - flags reset zero except oscillator-stop
module rio_core
    import rio_pkg::*;
#(
    parameter int PULSE_CYC = PULSE_TICKS,   // pulse width in osc ticks
    parameter int DIV_CYC   = OSC_DIV        // clock cycles per osc half period
) (
    // clock and reset
    input  wire logic              CLOCK,
    input  wire logic              RESET_N,
    // axi4-lite slave
    input  wire logic [5:0]        S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    input  wire logic [5:0]        S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    output logic [31:0]            S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,
    // event inputs from timekeeping and power monitor (asynchronous)
    input  wire rio_pkg::rio_events_t EVENTS,
    input  wire logic              ON_BACKUP,
    input  wire logic              RECALL_DONE,
    // interrupt pin
    output logic                   INT_O,
    output logic                   INT_OE_N,
    // nonvolatile image of square-wave settings
    input  wire logic [2:0]        NV_SQ_IN,
    output logic [2:0]             NV_SQ_OUT
);

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [6:0] sync1_r;   // first stage, read only by second
    logic [6:0] sync2_r;   // second stage
    logic [6:0] prev_r;    // previous second stage for edges

    // two flops per asynchronous input
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            sync1_r <= 7'h00;
            sync2_r <= 7'h00;
            prev_r  <= 7'h00;
        end else begin
            sync1_r <= {RECALL_DONE, ON_BACKUP, EVENTS};
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    logic       backup;      // running from backup supply
    logic       ready;       // power-up recall finished
    logic [4:0] ev_rise;     // event rising edges
    logic       bak_level;   // backup failure level
    assign backup    = sync2_r[5];
    assign ready     = sync2_r[6];
    assign ev_rise   = sync2_r[4:0] & ~prev_r[4:0];
    assign bak_level = sync2_r[1];

    // ----------------------------------------------------------------
    // oscillator tick divider
    // ----------------------------------------------------------------
    logic [15:0] div_r;      // clock cycles within half period
    logic        osc_tick;   // one pulse per osc half period
    logic [15:0] osc_cnt_r;  // divided oscillator chain

    assign osc_tick = (div_r == 16'(DIV_CYC - 1));

    // divide core clock down to oscillator half periods
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            div_r     <= 16'h0000;
            osc_cnt_r <= 16'h0000;
        end else if (osc_tick) begin
            div_r     <= 16'h0000;
            osc_cnt_r <= osc_cnt_r + 16'h0001;
        end else begin
            div_r     <= div_r + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] flags_r;     // event_flags
    logic [7:0] ictl_r;      // interrupt_control
    logic       flags_rd;    // flags register read accepted
    logic       wr_go;       // write accepted this cycle
    logic [5:0] wr_addr;     // write address
    logic [7:0] wr_data;     // write data low byte

    // ----------------------------------------------------------------
    // axi4-lite write path
    // ----------------------------------------------------------------
    logic       aw_have_r;   // address latched
    logic       w_have_r;    // data latched
    logic [5:0] aw_r;        // latched address
    logic [7:0] wd_r;        // latched data
    logic       wstb_r;      // lane 0 strobe

    assign S_AXI_AWREADY = !aw_have_r && !S_AXI_BVALID;
    assign S_AXI_WREADY  = !w_have_r && !S_AXI_BVALID;
    assign wr_go   = aw_have_r && w_have_r && !S_AXI_BVALID;
    assign wr_addr = aw_r;
    assign wr_data = wd_r;

    // accept address and data in either order, answer once both held
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            aw_r         <= 6'h00;
            wd_r         <= 8'h00;
            wstb_r       <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_have_r <= 1'b1;
                aw_r      <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_have_r <= 1'b1;
                wd_r     <= S_AXI_WDATA[7:0];
                wstb_r   <= S_AXI_WSTRB[0];
            end
            if (wr_go) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                // unmapped address answers slverr
                if (aw_r == ADDR_FLAGS || aw_r == ADDR_ICTL || aw_r == ADDR_STAT) begin
                    S_AXI_BRESP <= RESP_OKAY;
                end else begin
                    S_AXI_BRESP <= RESP_SLVERR;
                end
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read path
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;     // selected read word
    logic        rd_ok;      // mapped address

    assign S_AXI_ARREADY = !S_AXI_RVALID;
    assign flags_rd = S_AXI_ARVALID && S_AXI_ARREADY && (S_AXI_ARADDR == ADDR_FLAGS);

    // read data selection
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_ok  = 1'b1;
        case (S_AXI_ARADDR)
            ADDR_FLAGS: rd_mux = {24'h00_0000, flags_r};
            ADDR_ICTL:  rd_mux = {24'h00_0000, ictl_r};
            ADDR_STAT:  rd_mux = {29'h0000_0000, INT_O, ready, backup};
            default:    rd_ok  = 1'b0;
        endcase
    end

    // one read in flight, answer one cycle after address
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h0000_0000;
            S_AXI_RRESP  <= RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= rd_mux;
            S_AXI_RRESP  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // event flags
    // ----------------------------------------------------------------
    logic       wr_flags;    // software write to flags, lane 0
    logic [7:0] flags_nxt;   // next flags value

    assign wr_flags = wr_go && wstb_r && (wr_addr == ADDR_FLAGS);

    // read clears, hardware set wins over clear
    always_comb begin
        flags_nxt = flags_r;
        if (flags_rd) begin
            flags_nxt[FL_WDF] = 1'b0;
            flags_nxt[FL_AF]  = 1'b0;
            flags_nxt[FL_PF]  = 1'b0;
            flags_nxt[FL_BPF] = 1'b0;
        end
        if (wr_flags) begin
            flags_nxt[FL_W] = wr_data[FL_W];
            if (flags_r[FL_W]) begin
                // write bit open: calibration, oscillator-stop and backup-fail editable
                flags_nxt[FL_CAL]  = wr_data[FL_CAL];
                flags_nxt[FL_OSC_STOP_FLAG] = wr_data[FL_OSC_STOP_FLAG];
                flags_nxt[FL_BPF]  = wr_data[FL_BPF];
            end
        end
        // flags set whatever the enables say
        if (ev_rise[4]) flags_nxt[FL_WDF] = 1'b1;
        if (ev_rise[3]) flags_nxt[FL_AF]  = 1'b1;
        if (ev_rise[2]) flags_nxt[FL_PF]  = 1'b1;
        if (bak_level)  flags_nxt[FL_BPF] = 1'b1;
        if (ev_rise[0]) flags_nxt[FL_OSC_STOP_FLAG] = 1'b1;
    end

    // flags reset to zero; oscillator-stop flag reset to set
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            flags_r <= 8'h10;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // ----------------------------------------------------------------
    // interrupt control, square-wave fields kept in nv image
    // ----------------------------------------------------------------
    logic nv_loaded_r;   // nv image captured after reset

    // load nv square-wave bits once after reset, then software writes
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ictl_r      <= ICTL_RESET;
            nv_loaded_r <= 1'b0;
        end else if (!nv_loaded_r) begin
            nv_loaded_r <= 1'b1;
            ictl_r[IC_SQUARE_WAVE_ENABLE] <= NV_SQ_IN[2];
            ictl_r[IC_SQ1]  <= NV_SQ_IN[1];
            ictl_r[IC_SQ0]  <= NV_SQ_IN[0];
        end else if (wr_go && wstb_r && (wr_addr == ADDR_ICTL)) begin
            ictl_r <= wr_data;
        end
    end

    assign NV_SQ_OUT = {ictl_r[IC_SQUARE_WAVE_ENABLE], ictl_r[IC_SQ1], ictl_r[IC_SQ0]};

    // ----------------------------------------------------------------
    // interrupt request and pin state machine
    // ----------------------------------------------------------------
    logic           irq_req;     // any enabled flag set
    logic           irq_rise;    // new enabled event
    logic           irq_prev_r;  // previous request
    rio_pin_state_t pin_st_r;    // pin driver state
    logic [15:0]    pulse_cnt_r; // pulse width in osc ticks
    logic           active;      // interrupt currently asserted

    // enabled flag sources, blocked on backup or before recall
    assign irq_req = ready && !backup
                   && ((flags_r[FL_WDF] && ictl_r[IC_WIE])
                    || (flags_r[FL_AF]  && ictl_r[IC_AIE])
                    || (flags_r[FL_PF]  && ictl_r[IC_PFE]));
    assign irq_rise = irq_req && !irq_prev_r;

    // pulse or level drive of the interrupt
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            pin_st_r    <= PIN_IDLE;
            pulse_cnt_r <= 16'h0000;
            irq_prev_r  <= 1'b0;
        end else begin
            irq_prev_r <= irq_req;
            case (pin_st_r)
                PIN_IDLE: begin
                    if (irq_rise && ictl_r[IC_PL]) begin
                        pin_st_r    <= PIN_PULSE;
                        pulse_cnt_r <= 16'h0000;
                    end else if (irq_req && !ictl_r[IC_PL]) begin
                        pin_st_r <= PIN_LEVEL;
                    end
                end
                PIN_LEVEL: begin
                    if (!irq_req) begin
                        pin_st_r <= PIN_IDLE;
                    end
                end
                PIN_PULSE: begin
                    if (flags_rd || backup) begin
                        pin_st_r <= PIN_IDLE;
                    end else if (osc_tick) begin
                        if (pulse_cnt_r == 16'(PULSE_CYC - 1)) begin
                            pin_st_r <= PIN_IDLE;
                        end else begin
                            pulse_cnt_r <= pulse_cnt_r + 16'h0001;
                        end
                    end
                end
                default: begin
                    pin_st_r <= PIN_IDLE;
                end
            endcase
        end
    end

    assign active = (pin_st_r != PIN_IDLE);

    // ----------------------------------------------------------------
    // square wave select and output priority
    // ----------------------------------------------------------------
    logic sq_wave;   // selected square wave
    logic cal_wave;  // 512 Hz calibration tone
    logic drive;     // pin driven
    logic level;     // logical active level

    // osc_cnt bit k toggles at 32768/2^k Hz
    always_comb begin
        case ({ictl_r[IC_SQ1], ictl_r[IC_SQ0]})
            2'b00:   sq_wave = osc_cnt_r[15];   // 1 Hz
            2'b01:   sq_wave = osc_cnt_r[6];    // 512 Hz
            2'b10:   sq_wave = osc_cnt_r[3];    // 4096 Hz
            default: sq_wave = osc_cnt_r[0];    // raw oscillator
        endcase
    end
    assign cal_wave = osc_cnt_r[6];

    // calibration, then square wave, then interrupt, else hi-z
    always_comb begin
        drive = 1'b0;
        level = 1'b0;
        if (!ready || backup) begin
            drive = 1'b0;
        end else if (flags_r[FL_CAL]) begin
            drive = 1'b1;
            level = cal_wave;
        end else if (ictl_r[IC_SQUARE_WAVE_ENABLE]) begin
            drive = 1'b1;
            level = sq_wave;
        end else if (active) begin
            drive = 1'b1;
            level = 1'b1;
        end
    end

    // pin driver: push-pull high or open-drain low
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            INT_O    <= 1'b0;
            INT_OE_N <= 1'b1;
        end else if (ictl_r[IC_HL]) begin
            INT_O    <= level;
            INT_OE_N <= !drive;
        end else begin
            INT_O    <= 1'b0;
            INT_OE_N <= !(drive && level);
        end
    end

endmodule

// file: testbench/rio_core_properties.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// protocol and pin checker
// ----------------------------------------------------------------
module rio_core_properties
    import rio_pkg::*;
(
    // clock and reset
    input wire logic        CLOCK,
    input wire logic        RESET_N,
    // write path
    input wire logic [5:0]  S_AXI_AWADDR,
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0]  S_AXI_WSTRB,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    // read path
    input wire logic [5:0]  S_AXI_ARADDR,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0]  S_AXI_RRESP,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    // pin side
    input wire logic        ON_BACKUP,
    input wire logic        INT_OE_N,
    input wire logic [2:0]  NV_SQ_OUT
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    // handshakes and decode
    wire       wr_go  = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    wire       ar_go  = S_AXI_ARVALID && S_AXI_ARREADY;
    wire       aw_map = S_AXI_AWADDR inside {ADDR_FLAGS, ADDR_ICTL, ADDR_STAT};
    wire       ar_map = S_AXI_ARADDR inside {ADDR_FLAGS, ADDR_ICTL, ADDR_STAT};
    wire [2:0] nv_w   = {S_AXI_WDATA[4], S_AXI_WDATA[1:0]};
    property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read response dropped early");
    property p_ar_rdy; S_AXI_ARREADY == !S_AXI_RVALID; endproperty
    a_ar_rdy: assert property (p_ar_rdy) else $error("read address ready wrong");
    property p_r_ans; ar_go |=> S_AXI_RVALID; endproperty
    a_r_ans: assert property (p_r_ans) else $error("read answer late");
    property p_r_bad; ar_go && !ar_map |=> S_AXI_RRESP == RESP_SLVERR; endproperty
    a_r_bad: assert property (p_r_bad) else $error("unmapped read not refused");
    property p_r_ok; ar_go && ar_map |=> S_AXI_RRESP == RESP_OKAY && S_AXI_RDATA[31:8] == 24'h0;
    endproperty
    a_r_ok: assert property (p_r_ok) else $error("mapped read bad response or upper bits");
    property p_w_bad; wr_go && !aw_map |=> ##1 S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR;
    endproperty
    a_w_bad: assert property (p_w_bad) else $error("unmapped write not refused");
    property p_nv; wr_go && S_AXI_AWADDR == ADDR_ICTL && S_AXI_WSTRB[0]
        |=> ##1 NV_SQ_OUT == $past(nv_w, 2); endproperty
    a_nv: assert property (p_nv) else $error("square settings image not updated");
    property p_bak; ON_BACKUP [*6] |-> INT_OE_N; endproperty
    a_bak: assert property (p_bak) else $error("pin driven on backup supply");
endmodule

bind rio_core rio_core_properties rio_core_properties_i (
    .CLOCK, .RESET_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
    .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
    .S_AXI_RREADY, .ON_BACKUP, .INT_OE_N, .NV_SQ_OUT);

// file: testbench/rio_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// host side of the interrupt pin
// ----------------------------------------------------------------
module rio_host_model (
    // pin from the device
    input  wire logic int_o,
    input  wire logic int_oe_n,
    // host view
    input  wire logic hl,
    input  wire logic recall_done,
    output logic      level,
    output logic      act
);
    // released pin is pulled up
    assign level = int_oe_n ? 1'b1 : int_o;
    // pin ignored until recall done
    assign act = recall_done && !int_oe_n && (level == hl);
endmodule

// file: testbench/rio_core_tb.sv
`timescale 1ns/10ps
module rio_core_tb;
    import rio_pkg::*;
    // ----------------------------------------------------------------
    // bench signals
    // ----------------------------------------------------------------
    logic        clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0;
    logic        arv = 1'b0, rready = 1'b0, on_bak = 1'b0, recall = 1'b0, hl = 1'b1;
    logic [5:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, int_o, int_oe_n;
    logic        level, act, s, last;
    logic [2:0]  nv_out;
    rio_events_t ev = '0;
    int          n_mismatch = 0, checks = 0, n;

    rio_core #(.PULSE_CYC(8), .DIV_CYC(2)) rio_core_i (
        .CLOCK(clk), .RESET_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .EVENTS(ev), .ON_BACKUP(on_bak),
        .RECALL_DONE(recall), .INT_O(int_o), .INT_OE_N(int_oe_n), .NV_SQ_IN(3'h0),
        .NV_SQ_OUT(nv_out));
    rio_host_model rio_host_model_i (.int_o(int_o), .int_oe_n(int_oe_n), .hl(hl),
        .recall_done(recall), .level(level), .act(act));

    initial begin
        forever #4 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // write: release each channel when taken
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata  <= d;
        awv    <= 1'b1;
        wv     <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awv <= 1'b0;
            if (wready) wv <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        cmp("bresp", {30'h0, er}, {30'h0, bresp});
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arv    <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arv <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        cmp("rresp", {30'h0, er}, {30'h0, rresp});
        if (er == RESP_OKAY) cmp("rdata", e, rdata);
    endtask
    // hold events past the synchronisers
    task automatic fire(input logic [4:0] m);
        @(posedge clk);
        ev <= rio_events_t'(m);
        repeat (4) @(posedge clk);
        ev <= '0;
    endtask
    // wait up to c cycles for an active pin
    task automatic seen(input int c);
        s = 1'b0;
        for (int i = 0; i < c && !s; i++) begin
            @(posedge clk);
            s = act;
        end
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd(ADDR_FLAGS, 32'h10, RESP_OKAY);
        rd(ADDR_ICTL, {24'h0, ICTL_RESET}, RESP_OKAY);
        wr(6'h08, 32'hFF, RESP_SLVERR);
        rd(6'h04, 32'h0, RESP_SLVERR);
        rd(ADDR_ICTL, {24'h0, ICTL_RESET}, RESP_OKAY);
        $display("reset test done");
    endtask
    task automatic t_level();
        wr(ADDR_ICTL, 32'h88, RESP_OKAY);
        fire(5'h10);
        seen(12);
        cmp("pin_on", 1, s);
        repeat (30) @(posedge clk);
        cmp("pin_hold", 1, act);
        rd(ADDR_FLAGS, 32'h90, RESP_OKAY);
        repeat (3) @(posedge clk);
        cmp("pin_clear", 0, act);
        rd(ADDR_FLAGS, 32'h10, RESP_OKAY);
        $display("level test done");
    endtask
    task automatic t_off();
        wr(ADDR_ICTL, 32'h08, RESP_OKAY);
        fire(5'h0A);
        seen(12);
        cmp("pin_off", 0, s);
        rd(ADDR_FLAGS, 32'h58, RESP_OKAY);
        $display("disabled test done");
    endtask
    task automatic t_pulse();
        hl <= 1'b0;
        wr(ADDR_ICTL, 32'h24, RESP_OKAY);
        fire(5'h04);
        seen(12);
        cmp("pulse_on", 1, s);
        repeat (60) @(posedge clk);
        cmp("pulse_end", 0, act);
        rd(ADDR_FLAGS, 32'h30, RESP_OKAY);
        fire(5'h04);
        seen(12);
        rd(ADDR_FLAGS, 32'h30, RESP_OKAY);
        repeat (3) @(posedge clk);
        cmp("pulse_cut", 0, act);
        $display("pulse test done");
    endtask
    task automatic t_square();
        hl <= 1'b1;
        wr(ADDR_ICTL, 32'h9B, RESP_OKAY);
        fire(5'h10);
        n = 0;
        last = level;
        repeat (40) begin
            @(posedge clk);
            if (level !== last) n++;
            last = level;
        end
        cmp("sq_toggle", 1, n > 8);
        cmp("nv_sq", 3'h7, nv_out);
        wr(ADDR_ICTL, 32'h08, RESP_OKAY);
        rd(ADDR_FLAGS, 32'h90, RESP_OKAY);
        $display("square test done");
    endtask
    // last: an enabled event on backup leaves the pin quiet
    task automatic t_backup();
        wr(ADDR_ICTL, 32'h88, RESP_OKAY);
        on_bak <= 1'b1;
        repeat (8) @(posedge clk);
        fire(5'h10);
        seen(20);
        cmp("bak_quiet", 0, s);
        $display("backup test done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst_n  <= 1'b1;
        recall <= 1'b1;
        t_reset();
        t_level();
        t_off();
        t_pulse();
        t_square();
        t_backup();
        end_of_test();
    end
    initial begin
        #200000;
        n_mismatch++;
        end_of_test();
    end
endmodule
